// >>> ioch_pkg.sv
// How it works
// - Program save writes nonvolatile memory, about one second, then answers a colon.
// - Variable save writes all variables and arrays, about two seconds, then a colon.
// - Clear-output with index 0 to 15 drives that on-board line low only.
// - Fieldbus index is handle*1000 + (module-1)*4 + (bit-1).
// - Every unsolicited message goes to the one chosen destination, serial or Ethernet handle.
// - After reset unsolicited messages go to the main serial port.
// - Program output is unsolicited; the same output answering a host is solicited.
// - The routing setting reads back as the ASCII code of its letter.
// - Self-selecting letter from a host routes unsolicited traffic to the arriving port.
// - Interrupt mode 0 off, 1 on carriage return, 2 any character, -1 clears buffer.
// - A serial interrupt runs the communication routine in thread 0 only.
// - Data-use 0 interprets aux characters as commands; 1 feeds only the interrupt.
// - Received characters, status and count are readable by the program.
package ioch_pkg;

  // ==========================================================================
  // Commands and modes
  typedef enum logic [2:0] {
    IOCH_CMD_NONE       = 3'h0,
    IOCH_CMD_SAVE_PROG  = 3'h1,
    IOCH_CMD_SAVE_VARS  = 3'h2,
    IOCH_CMD_SAVE_PARAM = 3'h3,
    IOCH_CMD_CLEAR_OUT  = 3'h4,
    IOCH_CMD_SET_OUT    = 3'h5,
    IOCH_CMD_ROUTE      = 3'h6,
    IOCH_CMD_SERIAL_INT = 3'h7
  } ioch_cmd_t;

  localparam logic [1:0] CI_MODE_OFF = 2'h0;
  localparam logic [1:0] CI_MODE_CR  = 2'h1;
  localparam logic [1:0] CI_MODE_ANY = 2'h2;
  localparam logic [15:0] CI_ARG_CLEAR = 16'hFFFF;

  // ==========================================================================
  // Characters and port letters
  localparam logic [7:0] ACK_CHAR     = 8'h3A;
  localparam logic [7:0] ROUTE_SERIAL = 8'h53;
  localparam logic [7:0] ROUTE_SELF   = 8'h49;
  localparam logic [7:0] ROUTE_ETH_A  = 8'h41;
  localparam logic [7:0] CHAR_CR      = 8'h0D;
  localparam logic [1:0] COMM_INTERRUPT_ROUTINE_THREAD = 2'h0;

  // ==========================================================================
  // Output decode
  localparam int          ONBOARD_OUTS   = 16;
  localparam logic [15:0] FB_HANDLE_STEP = 16'h03E8;
  localparam logic [15:0] FB_POINTS      = 16'h0040;
  localparam int          FB_HANDLES     = 3;

  // ==========================================================================
  // Timing and wear
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint PROG_SAVE_MS  = 1000;
  localparam longint VAR_SAVE_MS   = 2000;
  localparam longint PARAM_SAVE_MS = 1000;
  localparam int PROG_SAVE_CYC  = int'(PROG_SAVE_MS * CLK_HZ / 1000);
  localparam int VAR_SAVE_CYC   = int'(VAR_SAVE_MS * CLK_HZ / 1000);
  localparam int PARAM_SAVE_CYC = int'(PARAM_SAVE_MS * CLK_HZ / 1000);
  localparam logic [13:0] WEAR_LIMIT  = 14'h2710;
  localparam logic [15:0] OUTS_RESET  = 16'h0000;

endpackage

// >>> ioch_save_engine.sv
`timescale 1ns/100ps
`default_nettype none
module ioch_save_engine
  import ioch_pkg::*;
#(
  parameter int PROG_CYCLES  = PROG_SAVE_CYC,
  parameter int VAR_CYCLES   = VAR_SAVE_CYC,
  parameter int PARAM_CYCLES = PARAM_SAVE_CYC
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Request side
  input  wire logic       start,
  input  wire logic [1:0] kind,
  output logic            busy,
  output logic            done,
  output logic            late,
  // Nonvolatile memory side
  output logic            nv_start,
  output logic [1:0]      nv_kind,
  input  wire logic       nv_done
);

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    SV_IDLE  = 3'b001,
    SV_WRITE = 3'b010,
    SV_ACK   = 3'b100
  } ioch_sv_t;

  typedef struct packed {
    ioch_sv_t    st;
    logic        go;
    logic [1:0]  kind;
    logic [31:0] cnt;
    logic [31:0] lim;
    logic        late;
  } ioch_sv_state_t;

  ioch_sv_state_t s_reg, s_next;

  assign busy     = s_reg.st != SV_IDLE;
  assign done     = s_reg.st == SV_ACK;
  assign late     = s_reg.late;
  assign nv_start = s_reg.go;
  assign nv_kind  = s_reg.kind;

  // ==========================================================================
  // Sequencer: start the write, wait for the memory, then announce completion
  always_comb
  begin
    s_next    = s_reg;
    s_next.go = 1'b0;
    unique case (s_reg.st)
      SV_IDLE:
        if (start)
        begin
          s_next.st   = SV_WRITE;
          s_next.go   = 1'b1;
          s_next.kind = kind;
          s_next.cnt  = 32'h0;
          s_next.late = 1'b0;
          // Typical duration per save kind, used to flag a slow part
          s_next.lim  = (kind == 2'h1) ? 32'(PROG_CYCLES) :
                        (kind == 2'h2) ? 32'(VAR_CYCLES) :
                                         32'(PARAM_CYCLES);
        end
      SV_WRITE:
      begin
        // The colon waits for the memory, however slow it turns out to be
        if (nv_done)
          s_next.st = SV_ACK;
        if (s_reg.cnt == s_reg.lim)
          s_next.late = 1'b1;
        else
          s_next.cnt = s_reg.cnt + 32'h1;
      end
      SV_ACK:
        s_next.st = SV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg    <= '0;
      s_reg.st <= SV_IDLE;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================================
  // Checks
  sequence s_begin;
    start && s_reg.st == SV_IDLE;
  endsequence

  sequence s_launch;
    nv_start && busy ##1 !nv_start && busy;
  endsequence

  a_save_launch: assert property (@(posedge clock) disable iff (!reset_n)
    s_begin |=> s_launch)
    else $error("save did not launch the memory write");

  a_save_finish: assert property (@(posedge clock) disable iff (!reset_n)
    (s_reg.st == SV_WRITE && nv_done) |=> done ##1 !busy)
    else $error("save completion not announced");

  a_save_held: assert property (@(posedge clock) disable iff (!reset_n)
    (s_reg.st == SV_WRITE && !nv_done) |=> busy && !done)
    else $error("save ended without the memory");

endmodule
`default_nettype wire

// >>> ioch_command_handler.sv
`timescale 1ns/100ps
`default_nettype none
module ioch_command_handler
  import ioch_pkg::*;
#(
  parameter int N_ETH        = 5,
  parameter int RX_DEPTH     = 16,
  parameter int PROG_CYCLES  = PROG_SAVE_CYC,
  parameter int VAR_CYCLES   = VAR_SAVE_CYC,
  parameter int PARAM_CYCLES = PARAM_SAVE_CYC,
  localparam int CW = $clog2(RX_DEPTH + 1),
  localparam int IW = $clog2(RX_DEPTH)
)(
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          reset_n,
  // Parsed command from the interpreter
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire ioch_cmd_t     cmd_code,
  input  wire logic [15:0]   cmd_arg,
  input  wire logic [15:0]   cmd_arg2,
  input  wire logic [7:0]    cmd_port,
  input  wire logic          cmd_from_host,
  output logic               cmd_reject,
  // Save acknowledgement
  output logic               ack_valid,
  output logic [7:0]         ack_char,
  output logic [7:0]         ack_port,
  output logic               save_late,
  output logic [13:0]        save_count,
  output logic               wear_limit_hit,
  // Nonvolatile memory
  output logic               nv_start,
  output logic [1:0]         nv_kind,
  input  wire logic          nv_done,
  // On-board and fieldbus outputs
  output logic [15:0]        out_bits,
  output logic               fb_valid,
  output logic               fb_level,
  output logic [1:0]         fb_handle,
  output logic [3:0]         fb_module,
  output logic [1:0]         fb_bit,
  // Message routing
  input  wire logic          msg_valid,
  input  wire logic          msg_from_program,
  input  wire logic [7:0]    msg_src_port,
  output logic               msg_out_valid,
  output logic [7:0]         msg_dest_port,
  output logic [7:0]         unsolicited_route_value,
  // Auxiliary serial receive
  input  wire logic          aux_rx_valid,
  input  wire logic [7:0]    aux_rx_char,
  output logic               interp_rx_valid,
  output logic [7:0]         interp_rx_char,
  // Communication interrupt and program variables
  output logic               comm_interrupt_routine_req,
  output logic [1:0]         comm_interrupt_routine_thread,
  output logic [1:0]         ci_mode,
  output logic               ci_data_use,
  input  wire logic [IW-1:0] rx_rd_idx,
  input  wire logic          rx_release,
  output logic [7:0]         rx_char_var,
  output logic [7:0]         rx_string_var,
  output logic [CW-1:0]      rx_number_var,
  output logic [7:0]         rx_status_var
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0]                outs;
    logic                       fb_valid;
    logic                       fb_level;
    logic [1:0]                 fb_handle;
    logic [3:0]                 fb_module;
    logic [1:0]                 fb_bit;
    logic [7:0]                 route;
    logic [1:0]                 ci_mode;
    logic                       data_use;
    logic [RX_DEPTH-1:0][7:0]   rx_buf;
    logic [CW-1:0]              rx_count;
    logic                       rx_over;
    logic                       rx_cr;
    logic [7:0]                 rx_last;
    logic [7:0]                 rd_char;
    logic                       comm_interrupt_routine;
    logic                       irx_valid;
    logic [7:0]                 irx_char;
    logic                       msg_valid;
    logic [7:0]                 msg_dest;
    logic                       ack_valid;
    logic [7:0]                 save_port;
    logic                       reject;
    logic [13:0]                wear;
  } ioch_state_t;

  ioch_state_t st_reg, st_next;
  logic        save_start;
  logic [1:0]  save_kind;
  logic        save_busy;
  logic        save_done;
  logic        accept;
  logic [1:0]  h;
  logic [15:0] rem;

  // Busy save refuses every command; the host is expected to wait anyway
  assign cmd_ready = !save_busy;
  assign accept    = cmd_valid && cmd_ready;

  // ==========================================================================
  // Fieldbus index split into handle, module and bit
  always_comb
  begin
    h   = 2'h0;
    rem = cmd_arg;
    for (int k = FB_HANDLES; k >= 1; k--)
      if (h == 2'h0 && cmd_arg >= 16'(k * FB_HANDLE_STEP))
      begin
        h   = 2'(k);
        rem = cmd_arg - 16'(k * FB_HANDLE_STEP);
      end
  end

  // ==========================================================================
  // Command, routing and receive logic
  always_comb
  begin
    st_next           = st_reg;
    st_next.fb_valid  = 1'b0;
    st_next.comm_interrupt_routine    = 1'b0;
    st_next.irx_valid = 1'b0;
    st_next.msg_valid = 1'b0;
    st_next.ack_valid = save_done;
    st_next.reject    = 1'b0;
    save_start        = 1'b0;
    save_kind         = 2'h0;
    if (accept)
      unique case (cmd_code)
        IOCH_CMD_SAVE_PROG, IOCH_CMD_SAVE_VARS, IOCH_CMD_SAVE_PARAM:
        begin
          save_start        = 1'b1;
          save_kind         = cmd_code[1:0];
          st_next.save_port = cmd_port;
          // Wear counter saturates so software can see the limit
          if (st_reg.wear != WEAR_LIMIT)
            st_next.wear = st_reg.wear + 14'h1;
        end
        IOCH_CMD_CLEAR_OUT, IOCH_CMD_SET_OUT:
          if (cmd_arg < 16'(ONBOARD_OUTS))
            st_next.outs[cmd_arg[3:0]] = (cmd_code == IOCH_CMD_SET_OUT);
          else if (h != 2'h0 && rem < FB_POINTS)
          begin
            st_next.fb_valid  = 1'b1;
            st_next.fb_level  = (cmd_code == IOCH_CMD_SET_OUT);
            st_next.fb_handle = h;
            st_next.fb_module = rem[5:2];
            st_next.fb_bit    = rem[1:0];
          end
          else
            st_next.reject = 1'b1;
        IOCH_CMD_ROUTE:
          if (cmd_arg[7:0] == ROUTE_SELF)
            if (cmd_from_host)
              st_next.route = cmd_port;
            else
              st_next.reject = 1'b1;
          else if (cmd_arg[7:0] == ROUTE_SERIAL ||
                   (cmd_arg[7:0] >= ROUTE_ETH_A && cmd_arg[7:0] < ROUTE_ETH_A + 8'(N_ETH)))
            st_next.route = cmd_arg[7:0];
          else
            st_next.reject = 1'b1;
        IOCH_CMD_SERIAL_INT:
        begin
          if (cmd_arg == CI_ARG_CLEAR)
          begin
            st_next.rx_count = '0;
            st_next.rx_over  = 1'b0;
            st_next.rx_cr    = 1'b0;
          end
          else if (cmd_arg <= 16'(CI_MODE_ANY))
            st_next.ci_mode = cmd_arg[1:0];
          else
            st_next.reject = 1'b1;
          if (cmd_arg2 <= 16'h0001)
            st_next.data_use = cmd_arg2[0];
          else
            st_next.reject = 1'b1;
        end
        default:
          st_next.reject = 1'b1;
      endcase

    // Program done with the buffer; placed before the append so a new char survives
    if (rx_release)
    begin
      st_next.rx_count = '0;
      st_next.rx_over  = 1'b0;
      st_next.rx_cr    = 1'b0;
    end

    // Incoming aux character
    if (aux_rx_valid)
    begin
      if (!st_reg.data_use)
      begin
        st_next.irx_valid = 1'b1;
        st_next.irx_char  = aux_rx_char;
      end
      if (st_reg.ci_mode != CI_MODE_OFF)
      begin
        st_next.rx_last = aux_rx_char;
        // A full buffer keeps what it holds and marks the loss
        if (st_next.rx_count < CW'(RX_DEPTH))
        begin
          st_next.rx_buf[st_next.rx_count[IW-1:0]] = aux_rx_char;
          st_next.rx_count = st_next.rx_count + CW'(1);
        end
        else
          st_next.rx_over = 1'b1;
        if (aux_rx_char == CHAR_CR)
          st_next.rx_cr = 1'b1;
        st_next.comm_interrupt_routine = (st_reg.ci_mode == CI_MODE_ANY) ||
                         (aux_rx_char == CHAR_CR);
      end
    end
    st_next.rd_char = st_reg.rx_buf[rx_rd_idx];

    // Program output follows the route; answers go back to the asker
    if (msg_valid)
    begin
      st_next.msg_valid = 1'b1;
      st_next.msg_dest  = msg_from_program ? st_reg.route : msg_src_port;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg       <= '0;
      st_reg.outs  <= OUTS_RESET;
      st_reg.route <= ROUTE_SERIAL;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // Save sequencer
  ioch_save_engine #(
    .PROG_CYCLES  (PROG_CYCLES),
    .VAR_CYCLES   (VAR_CYCLES),
    .PARAM_CYCLES (PARAM_CYCLES)
  ) u_save (
    .clock    (clock),
    .reset_n  (reset_n),
    .start    (save_start),
    .kind     (save_kind),
    .busy     (save_busy),
    .done     (save_done),
    .late     (save_late),
    .nv_start (nv_start),
    .nv_kind  (nv_kind),
    .nv_done  (nv_done)
  );

  // ==========================================================================
  // Outputs
  assign cmd_reject              = st_reg.reject;
  assign ack_valid               = st_reg.ack_valid;
  assign ack_char                = ACK_CHAR;
  assign ack_port                = st_reg.save_port;
  assign save_count              = st_reg.wear;
  assign wear_limit_hit          = st_reg.wear == WEAR_LIMIT;
  assign out_bits                = st_reg.outs;
  assign fb_valid                = st_reg.fb_valid;
  assign fb_level                = st_reg.fb_level;
  assign fb_handle               = st_reg.fb_handle;
  assign fb_module               = st_reg.fb_module;
  assign fb_bit                  = st_reg.fb_bit;
  assign msg_out_valid           = st_reg.msg_valid;
  assign msg_dest_port           = st_reg.msg_dest;
  assign unsolicited_route_value = st_reg.route;
  assign interp_rx_valid         = st_reg.irx_valid;
  assign interp_rx_char          = st_reg.irx_char;
  assign comm_interrupt_routine_req              = st_reg.comm_interrupt_routine;
  assign comm_interrupt_routine_thread           = COMM_INTERRUPT_ROUTINE_THREAD;
  assign ci_mode                 = st_reg.ci_mode;
  assign ci_data_use             = st_reg.data_use;
  assign rx_char_var             = st_reg.rx_last;
  assign rx_string_var           = st_reg.rd_char;
  assign rx_number_var           = st_reg.rx_count;
  assign rx_status_var           = {6'h00, st_reg.rx_over, st_reg.rx_cr};

  // ==========================================================================
  // Checks
  a_route_change: assert property (@(posedge clock) disable iff (!reset_n)
    st_reg.route != $past(st_reg.route) |-> $past(accept && cmd_code == IOCH_CMD_ROUTE))
    else $error("route changed without a routing command");

  a_unsol_dest: assert property (@(posedge clock) disable iff (!reset_n)
    msg_valid && msg_from_program |=> msg_out_valid && msg_dest_port == $past(st_reg.route))
    else $error("unsolicited message misrouted");

  a_solicit_dest: assert property (@(posedge clock) disable iff (!reset_n)
    msg_valid && !msg_from_program |=> msg_dest_port == $past(msg_src_port))
    else $error("solicited reply misrouted");

  a_clear_bit: assert property (@(posedge clock) disable iff (!reset_n)
    accept && cmd_code == IOCH_CMD_CLEAR_OUT && cmd_arg < 16'h0010
    |=> !out_bits[$past(cmd_arg[3:0])])
    else $error("on-board output not cleared");

  a_fb_decode: assert property (@(posedge clock) disable iff (!reset_n)
    accept && cmd_code == IOCH_CMD_CLEAR_OUT && cmd_arg == 16'h07D5
    |=> fb_valid && fb_handle == 2'h2 && fb_module == 4'h1 && fb_bit == 2'h1 && !fb_level)
    else $error("fieldbus index decoded wrongly");

  a_self_route: assert property (@(posedge clock) disable iff (!reset_n)
    accept && cmd_code == IOCH_CMD_ROUTE && cmd_arg[7:0] == ROUTE_SELF && cmd_from_host
    |=> unsolicited_route_value == $past(cmd_port))
    else $error("self routing ignored");

  a_comm_interrupt_routine_cr: assert property (@(posedge clock) disable iff (!reset_n)
    ci_mode == CI_MODE_CR && aux_rx_valid && aux_rx_char == CHAR_CR
    |=> comm_interrupt_routine_req && comm_interrupt_routine_thread == 2'h0)
    else $error("carriage return did not interrupt");

  a_no_interp: assert property (@(posedge clock) disable iff (!reset_n)
    ci_data_use && aux_rx_valid |=> !interp_rx_valid)
    else $error("character interpreted while reserved");

  a_ack_colon: assert property (@(posedge clock) disable iff (!reset_n)
    save_done |=> ack_valid && ack_char == 8'h3A ##1 !ack_valid)
    else $error("save not acknowledged with a colon");

  a_rx_hold: assert property (@(posedge clock) disable iff (!reset_n)
    comm_interrupt_routine_req && !rx_release && !accept |=> rx_number_var >= $past(rx_number_var))
    else $error("buffered characters lost");

endmodule
`default_nettype wire

// >>> ioch_nv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Nonvolatile memory stand-in: answers each write after a settable delay
module ioch_nv_model
(
  // Clock
  input  wire logic       clock,
  // Write request and completion
  input  wire logic       nv_start,
  input  wire logic [7:0] delay,
  output logic            nv_done
);
  initial nv_done = 1'b0;
  // Done is one pulse, so a stale level can never end a later save
  always @(posedge clock)
  begin
    nv_done <= 1'b0;
    if (nv_start === 1'b1)
    begin
      repeat (delay) @(posedge clock);
      nv_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> ioch_command_handler_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ioch_command_handler_tb_top;
  import ioch_pkg::*;
  // ==========================================================================
  // Signals
  logic clock, reset_n, cmd_valid, cmd_ready, cmd_from_host, cmd_reject, ack_valid, save_late, wear_limit_hit;
  logic nv_start, nv_done, fb_valid, fb_level, msg_valid, msg_from_program, msg_out_valid, aux_rx_valid;
  logic interp_rx_valid, comm_interrupt_routine_req, ci_data_use, rx_release;
  ioch_cmd_t cmd_code;
  logic [15:0] cmd_arg, cmd_arg2, out_bits, exp_outs;
  logic [13:0] save_count;
  logic [7:0] cmd_port, ack_char, ack_port, msg_src_port, msg_dest_port, unsolicited_route_value, nv_delay;
  logic [7:0] aux_rx_char, interp_rx_char, rx_char_var, rx_string_var, rx_status_var;
  logic [4:0] rx_number_var;
  logic [3:0] fb_module, rx_rd_idx;
  logic [1:0] nv_kind, fb_handle, fb_bit, comm_interrupt_routine_thread, ci_mode;
  logic [31:0] seed = 32'h00004834;
  int checks = 0;
  int bad_count = 0;

  ioch_command_handler #(.PROG_CYCLES(20), .VAR_CYCLES(40), .PARAM_CYCLES(20)) u_dut (
    .clock, .reset_n, .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg, .cmd_arg2, .cmd_port, .cmd_from_host,
    .cmd_reject, .ack_valid, .ack_char, .ack_port, .save_late, .save_count, .wear_limit_hit, .nv_start,
    .nv_kind, .nv_done, .out_bits, .fb_valid, .fb_level, .fb_handle, .fb_module, .fb_bit, .msg_valid,
    .msg_from_program, .msg_src_port, .msg_out_valid, .msg_dest_port, .unsolicited_route_value,
    .aux_rx_valid, .aux_rx_char, .interp_rx_valid, .interp_rx_char, .comm_interrupt_routine_req, .comm_interrupt_routine_thread,
    .ci_mode, .ci_data_use, .rx_rd_idx, .rx_release, .rx_char_var, .rx_string_var, .rx_number_var,
    .rx_status_var);
  ioch_nv_model u_nv (.clock(clock), .nv_start(nv_start), .delay(nv_delay), .nv_done(nv_done));

  // ==========================================================================
  // Helpers
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Fieldbus point number from handle, module and bit
  function automatic logic [15:0] fb_index(input int h, m, b);
    return 16'(h * 1000 + (m - 1) * 4 + (b - 1));
  endfunction
  task automatic chk(input logic [15:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Held until the edge that samples cmd_ready high; effects are checked half a cycle on
  task automatic cmd(input ioch_cmd_t c, input logic [15:0] a, b, input logic [7:0] p, input logic h);
    @(negedge clock);
    cmd_code = c;
    {cmd_valid, cmd_arg, cmd_arg2, cmd_port, cmd_from_host} = {1'b1, a, b, p, h};
    do @(posedge clock); while (cmd_ready !== 1'b1);
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task automatic save(input ioch_cmd_t c, input logic [7:0] p, input logic late, input logic [1:0] k);
    int n;
    cmd(c, 16'h0000, 16'h0000, p, 1'b1);
    chk(cmd_ready, 1'b0, "busy refuses");
    n = 0;
    while (ack_valid !== 1'b1 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    chk(ack_char, ACK_CHAR, "ack char");
    chk(ack_port, p, "ack port");
    chk({ack_valid, save_late, nv_kind}, {1'b1, late, k}, "save result");
  endtask
  task automatic msg(input logic prog, input logic [7:0] src, exp);
    @(negedge clock);
    {msg_valid, msg_from_program, msg_src_port} = {1'b1, prog, src};
    @(negedge clock);
    msg_valid = 1'b0;
    chk({msg_out_valid, msg_dest_port}, {1'b1, exp}, "message dest");
  endtask
  task automatic rx(input logic [7:0] ch);
    @(negedge clock);
    {aux_rx_valid, aux_rx_char} = {1'b1, ch};
    @(negedge clock);
    aux_rx_valid = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, far longer than the few hundred cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    int h, m, b, k;
    {reset_n, cmd_valid, msg_valid, msg_from_program, aux_rx_valid, rx_release, cmd_from_host} = 7'h00;
    cmd_code = IOCH_CMD_NONE;
    {cmd_arg, cmd_arg2, cmd_port, msg_src_port, aux_rx_char, rx_rd_idx} = '0;
    nv_delay = 8'h05;
    repeat (12) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    chk(unsolicited_route_value, ROUTE_SERIAL, "route reset");
    chk({ci_mode, ci_data_use}, 3'h0, "serial cfg reset");
    chk(out_bits, OUTS_RESET, "outputs reset");
    msg(1'b1, 8'h42, ROUTE_SERIAL);
    save(IOCH_CMD_SAVE_PROG, ROUTE_SERIAL, 1'b0, 2'h1);
    nv_delay = 8'h3C;
    save(IOCH_CMD_SAVE_VARS, ROUTE_ETH_A, 1'b1, 2'h2);
    save(IOCH_CMD_SAVE_PARAM, 8'h42, 1'b1, 2'h3);
    chk({1'b0, wear_limit_hit, save_count}, 16'h0003, "save count");
    $display("test saves done");
    // Set every line, then clear corners and random picks
    for (k = 0; k < 16; k++)
      cmd(IOCH_CMD_SET_OUT, 16'(k), 16'h0000, ROUTE_SERIAL, 1'b1);
    exp_outs = 16'hFFFF;
    for (k = 0; k < 6; k++)
    begin
      h = (k == 0) ? 15 : (k == 1) ? 0 : int'(xs() % 16);
      cmd(IOCH_CMD_CLEAR_OUT, 16'(h), 16'h0000, ROUTE_SERIAL, 1'b1);
      exp_outs &= ~(16'h0001 << h);
      chk(out_bits, exp_outs, "outputs");
    end
    for (k = 0; k < 6; k++)
    begin
      h = (k == 0) ? 3 : (k == 1) ? 2 : 1 + int'(xs() % 3);
      m = (k == 0) ? 16 : (k == 1) ? 2 : 1 + int'(xs() % 16);
      b = (k == 0) ? 4 : (k == 1) ? 2 : 1 + int'(xs() % 4);
      cmd(IOCH_CMD_CLEAR_OUT, fb_index(h, m, b), 16'h0000, ROUTE_SERIAL, 1'b1);
      chk({fb_valid, fb_level, fb_handle, fb_module, fb_bit}, {2'b10, 2'(h), 4'(m - 1), 2'(b - 1)}, "fb");
    end
    $display("test outputs done");
    cmd(IOCH_CMD_ROUTE, {8'h00, ROUTE_ETH_A}, 16'h0000, ROUTE_SERIAL, 1'b1);
    chk(unsolicited_route_value, ROUTE_ETH_A, "route value");
    msg(1'b1, 8'h43, ROUTE_ETH_A);
    msg(1'b0, 8'h43, 8'h43);
    cmd(IOCH_CMD_ROUTE, {8'h00, ROUTE_SELF}, 16'h0000, 8'h43, 1'b1);
    chk(unsolicited_route_value, 8'h43, "route to sender");
    // First letter past the last handle, then self-select from the program: both refused
    cmd(IOCH_CMD_ROUTE, 16'h0046, 16'h0000, ROUTE_SERIAL, 1'b1);
    chk({cmd_reject, unsolicited_route_value}, {1'b1, 8'h43}, "bad letter");
    cmd(IOCH_CMD_ROUTE, {8'h00, ROUTE_SELF}, 16'h0000, ROUTE_ETH_A, 1'b0);
    chk({cmd_reject, unsolicited_route_value}, {1'b1, 8'h43}, "self from program");
    msg(1'b1, ROUTE_SERIAL, 8'h43);
    $display("test routing done");
    cmd(IOCH_CMD_SERIAL_INT, 16'h0001, 16'h0001, ROUTE_SERIAL, 1'b1);
    chk({ci_mode, ci_data_use}, {CI_MODE_CR, 1'b1}, "serial cfg");
    rx(8'h78);
    chk({comm_interrupt_routine_req, interp_rx_valid}, 2'b00, "plain char");
    rx(CHAR_CR);
    chk({comm_interrupt_routine_req, comm_interrupt_routine_thread}, {1'b1, COMM_INTERRUPT_ROUTINE_THREAD}, "interrupt");
    chk({rx_char_var, 3'h0, rx_number_var}, {CHAR_CR, 8'h02}, "rx vars");
    chk(rx_status_var, 8'h01, "rx status");
    @(negedge clock);
    chk(rx_string_var, 8'h78, "buffer head");
    cmd(IOCH_CMD_SERIAL_INT, CI_ARG_CLEAR, 16'h0000, ROUTE_SERIAL, 1'b1);
    chk({rx_status_var, 3'h0, rx_number_var}, 16'h0000, "buffer clear");
    cmd(IOCH_CMD_SERIAL_INT, 16'h0002, 16'h0000, ROUTE_SERIAL, 1'b1);
    rx(8'h71);
    chk({comm_interrupt_routine_req, interp_rx_valid, interp_rx_char}, {2'b11, 8'h71}, "any char");
    // Release and a new character in one cycle: the new one is kept at the head
    @(negedge clock);
    {rx_release, aux_rx_valid, aux_rx_char} = {2'b11, 8'h55};
    @(negedge clock);
    {rx_release, aux_rx_valid} = 2'b00;
    chk({3'h0, rx_number_var, rx_char_var}, {8'h01, 8'h55}, "release keeps new");
    @(negedge clock);
    chk(rx_string_var, 8'h55, "new head");
    cmd(IOCH_CMD_SERIAL_INT, 16'h0000, 16'h0000, ROUTE_SERIAL, 1'b1);
    rx(CHAR_CR);
    chk(comm_interrupt_routine_req, 1'b0, "interrupt off");
    $display("test serial interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
